// ---- fdsup_pkg.sv ----
// Package for the drive fault supervisor: register map, fields, reset values and timing.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port with byte addresses.
package fdsup_pkg;

   localparam int CLK_PERIOD_NS        = 10;
   localparam int DUAL_HOLD_MS         = 500;
   localparam int DUAL_HOLD_CYCLES     = DUAL_HOLD_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int BLINK_HALF_MS        = 250;
   localparam int BLINK_HALF_CYCLES    = BLINK_HALF_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int CNT_W                = 27;

   localparam logic [4:0] ADDR_CTRL    = 5'h00;
   localparam logic [4:0] ADDR_LEVEL   = 5'h04;
   localparam logic [4:0] ADDR_STATUS  = 5'h08;
   localparam logic [4:0] ADDR_MASK    = 5'h0C;
   localparam logic [4:0] ADDR_STATE   = 5'h10;

   localparam int CTRL_MODE_BIT        = 0;
   localparam int CTRL_SOURCE_BIT      = 1;
   localparam int CTRL_RESPONSE_BIT    = 2;
   localparam int CTRL_STOP_BIT        = 3;
   localparam int CTRL_W               = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET  = 4'h0;
   localparam logic [15:0]       LEVEL_RESET = 16'h0000;

   localparam int EV_W                 = 5;
   localparam logic [EV_W-1:0] EV_RESET = 5'h00;

   // Sticky event layout, shared by status and mask registers.
   typedef struct packed {
      logic dual_direction;
      logic output_block;
      logic sequence_error;
      logic undertorque_trip;
      logic undertorque_warn;
   } fdsup_event_type;

   // Control terminal and measurement inputs.
   typedef struct packed {
      logic        fwd_run;
      logic        rev_run;
      logic        drive_running;
      logic        sequence_change;
      logic        local_remote_sel;
      logic        external_output_block;
      logic [15:0] output_current;
      logic [15:0] output_torque;
   } fdsup_terminal_type;

   // Responses toward the power output stage and the display.
   typedef struct packed {
      logic power_output_enable;
      logic coast_stop;
      logic decel_stop;
      logic fault_contact;
      logic undertorque_alarm;
      logic sequence_error_lamp;
      logic output_block_lamp;
      logic dual_direction_fault;
   } fdsup_response_type;

endpackage

// ---- fdsup_hold_timer.sv ----
// Hold timer: counts cycles while its input stays high and clears when it drops.
// Assumes an input synchronous to clk.
`timescale 1ns/1ns
module fdsup_hold_timer #(
   parameter int LIMIT = fdsup_pkg::DUAL_HOLD_CYCLES
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic hold_in,
   output logic      expired
);
   import fdsup_pkg::*;

   logic [CNT_W-1:0] count_reg;

   always_ff @(posedge clk) begin
      if (sys_rst || !hold_in) begin
         count_reg <= '0;
      end else if (count_reg < CNT_W'(LIMIT)) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   assign expired = hold_in && (count_reg >= CNT_W'(LIMIT - 1));
endmodule

// ---- fdsup_blinker.sv ----
// Blink source for flashing indications: a square wave with a fixed half period.
// Assumes a free-running clk.
`timescale 1ns/1ns
module fdsup_blinker #(
   parameter int HALF = fdsup_pkg::BLINK_HALF_CYCLES
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   output logic      blink
);
   import fdsup_pkg::*;

   logic [CNT_W-1:0] count_reg;
   logic             blink_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_reg <= '0;
         blink_reg <= 1'b0;
      end else if (count_reg >= CNT_W'(HALF - 1)) begin
         count_reg <= '0;
         blink_reg <= ~blink_reg;
      end else begin
         count_reg <= count_reg + 1'b1;
      end
   end

   assign blink = blink_reg;
endmodule

// ---- fdsup_top.sv ----
// Drive fault supervisor: undertorque, sequence error, external output block and
// simultaneous direction command supervision, with an Avalon-MM register port.
// Assumes terminal inputs synchronous to clk and a master that holds each request.
`timescale 1ns/1ns

// What this block does
// - Undertorque as warning flashes the alarm and leaves fault contacts unchanged.
// - Open-loop mode detects undertorque when output current falls below the level.
// - Vector mode compares current or torque, as selected, against the level.
// - Undertorque reaction follows the response selection: warning or trip.
// - Undertorque trip removes power output at once so the motor coasts.
// - A sequence change while running flags a flashing sequence error and coasts.
// - A local/remote change while running is also a sequence error with coasting.
// - External output block flashes its lamp and removes output while asserted.
// - Forward and reverse together for half a second flag a direction fault.
// - A direction fault stops the motor using the selected stop method.
module fdsup_top #(
   parameter int DUAL_HOLD  = fdsup_pkg::DUAL_HOLD_CYCLES,
   parameter int BLINK_HALF = fdsup_pkg::BLINK_HALF_CYCLES
) (
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   input  wire logic [4:0]                   avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [31:0]                  avs_writedata,
   input  wire logic [3:0]                   avs_byteenable,
   output logic [31:0]                       avs_readdata,
   output logic                              avs_waitrequest,
   input  wire fdsup_pkg::fdsup_terminal_type terminals,
   output fdsup_pkg::fdsup_response_type      response,
   output logic                              irq
);
   import fdsup_pkg::*;

   // Register state.
   logic [CTRL_W-1:0]  ctrl_reg;
   logic [15:0]        level_reg;
   fdsup_event_type    status_reg;
   fdsup_event_type    status_next;
   fdsup_event_type    mask_reg;
   fdsup_event_type    events;
   logic [31:0]        readdata_reg;
   logic               rd_status_reg;
   logic               access;
   logic               answering;
   logic               bus_take;
   logic               rd_first;
   logic               wr_take;
   logic               wr_ctrl;
   logic               wr_level;
   logic               wr_mask;
   logic [31:0]        read_mux;
   logic [5:0]         state_word;
   logic [EV_W-1:0]    status_clear;
   logic [EV_W-1:0]    sticky_next;

   // Bus answer sequencer.
   typedef enum {
      BUS_IDLE,
      BUS_ANSWER
   } fdsup_bus_st_type;

   fdsup_bus_st_type   bus_state_reg;
   fdsup_bus_st_type   bus_state_next;

   // Supervision state.
   logic               running_reg;
   logic               seq_change_reg;
   logic               local_remote_reg;
   logic               block_prev_reg;
   logic               ut_trip_reg;
   logic               seq_err_reg;
   logic               dual_fault_reg;
   logic               ut_below;
   logic               ut_detect;
   logic               ut_warn;
   logic               ut_trip_set;
   logic               seq_err_set;
   logic               dual_expired;
   logic               dual_set;
   logic               both_dir;
   logic               seq_rise;
   logic               lr_toggle;
   logic               block_rise;
   logic               coast_cause;
   logic               decel_cause;
   logic               blink;
   logic [15:0]        ut_measure;
   fdsup_response_type response_reg;
   fdsup_response_type response_next;

   // Control fields.
   logic               mode_vector;
   logic               source_torque;
   logic               response_trip;
   logic               stop_coast;

   assign mode_vector   = ctrl_reg[CTRL_MODE_BIT];
   assign source_torque = ctrl_reg[CTRL_SOURCE_BIT];
   assign response_trip = ctrl_reg[CTRL_RESPONSE_BIT];
   assign stop_coast    = ctrl_reg[CTRL_STOP_BIT];

   // Bus handshake: every access is answered on the second edge.
   assign access          = avs_read || avs_write;
   assign answering       = (bus_state_reg == BUS_ANSWER);
   assign avs_waitrequest = access && !answering;
   assign bus_take        = access && answering;
   assign rd_first        = avs_read && !answering;
   assign avs_readdata    = readdata_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_state_reg <= BUS_IDLE;
      end else begin
         bus_state_reg <= bus_state_next;
      end
   end

   always_comb begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         BUS_IDLE: begin
            if (access) begin
               bus_state_next = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            bus_state_next = BUS_IDLE;
         end
         default: begin
            bus_state_next = BUS_IDLE;
         end
      endcase
   end

   // Write strobes, decoded once for all registers.
   assign wr_take  = bus_take && avs_write;
   assign wr_ctrl  = wr_take && (avs_address == ADDR_CTRL);
   assign wr_level = wr_take && (avs_address == ADDR_LEVEL);
   assign wr_mask  = wr_take && (avs_address == ADDR_MASK);

   // Live fault state as software sees it.
   assign state_word[0] = ut_trip_reg;
   assign state_word[1] = seq_err_reg;
   assign state_word[2] = dual_fault_reg;
   assign state_word[3] = terminals.external_output_block;
   assign state_word[4] = ut_warn;
   assign state_word[5] = response_reg.power_output_enable;

   // Read data is prepared on the first edge and stands at the accepting edge.
   always_comb begin
      read_mux = 32'h0000_0000;
      if (avs_address == ADDR_CTRL) begin
         read_mux[CTRL_W-1:0] = ctrl_reg;
      end else if (avs_address == ADDR_LEVEL) begin
         read_mux[15:0] = level_reg;
      end else if (avs_address == ADDR_STATUS) begin
         read_mux[EV_W-1:0] = status_reg;
      end else if (avs_address == ADDR_MASK) begin
         read_mux[EV_W-1:0] = mask_reg;
      end else if (avs_address == ADDR_STATE) begin
         read_mux[5:0] = state_word;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         readdata_reg  <= 32'h0000_0000;
         rd_status_reg <= 1'b0;
      end else if (rd_first) begin
         readdata_reg  <= read_mux;
         rd_status_reg <= (avs_address == ADDR_STATUS);
      end
   end

   // Writable registers, honouring byte enables.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_ctrl && avs_byteenable[0]) begin
         ctrl_reg <= avs_writedata[CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         level_reg <= LEVEL_RESET;
      end else if (wr_level) begin
         if (avs_byteenable[0]) begin
            level_reg[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            level_reg[15:8] <= avs_writedata[15:8];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_reg <= EV_RESET;
      end else if (wr_mask && avs_byteenable[0]) begin
         mask_reg <= avs_writedata[EV_W-1:0];
      end
   end

   // Undertorque detection.
   always_comb begin
      if (mode_vector && source_torque) begin
         ut_measure = terminals.output_torque;
      end else begin
         ut_measure = terminals.output_current;
      end
   end

   assign ut_below    = ut_measure < level_reg;
   assign ut_detect   = terminals.drive_running && ut_below;
   assign ut_warn     = ut_detect && !response_trip;
   assign ut_trip_set = ut_detect && response_trip;

   // Input history for change detection while running.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         running_reg      <= 1'b0;
         seq_change_reg   <= 1'b0;
         local_remote_reg <= 1'b0;
         block_prev_reg   <= 1'b0;
      end else begin
         running_reg      <= terminals.drive_running;
         seq_change_reg   <= terminals.sequence_change;
         local_remote_reg <= terminals.local_remote_sel;
         block_prev_reg   <= terminals.external_output_block;
      end
   end

   assign seq_rise    = terminals.sequence_change && !seq_change_reg;
   assign lr_toggle   = terminals.local_remote_sel != local_remote_reg;
   assign seq_err_set = running_reg && terminals.drive_running && (seq_rise || lr_toggle);
   assign block_rise  = terminals.external_output_block && !block_prev_reg;
   assign both_dir    = terminals.fwd_run && terminals.rev_run;

   // Simultaneous direction command timer.
   fdsup_hold_timer #(
      .LIMIT (DUAL_HOLD)
   ) u_dual_timer (
      .clk     (clk),
      .sys_rst (sys_rst),
      .hold_in (both_dir),
      .expired (dual_expired)
   );

   assign dual_set = dual_expired;

   fdsup_blinker #(
      .HALF (BLINK_HALF)
   ) u_blinker (
      .clk     (clk),
      .sys_rst (sys_rst),
      .blink   (blink)
   );

   // Latched faults, held until reset.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ut_trip_reg    <= 1'b0;
         seq_err_reg    <= 1'b0;
         dual_fault_reg <= 1'b0;
      end else begin
         if (ut_trip_set) begin
            ut_trip_reg <= 1'b1;
         end
         if (seq_err_set) begin
            seq_err_reg <= 1'b1;
         end
         if (dual_set) begin
            dual_fault_reg <= 1'b1;
         end
      end
   end

   // Event sources, one for each sticky status bit.
   always_comb begin
      events                  = EV_RESET;
      events.undertorque_warn = ut_warn;
      events.undertorque_trip = ut_trip_set;
      events.sequence_error   = seq_err_set;
      events.output_block     = block_rise;
      events.dual_direction   = dual_set;
   end

   // A status read clears only the bits it returned.
   assign status_clear = (bus_take && avs_read && rd_status_reg) ? readdata_reg[EV_W-1:0] : EV_RESET;

   // Each sticky bit; an event in the clearing cycle wins.
   for (genvar i = 0; i < EV_W; i++) begin : g_sticky
      assign sticky_next[i] = events[i] || (status_reg[i] && !status_clear[i]);
   end

   assign status_next = sticky_next;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_reg <= EV_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_next & mask_reg);
      end
   end

   // Any coast cause removes output at once; deceleration only when nothing asks to coast.
   assign coast_cause = ut_trip_reg || ut_trip_set ||
                        seq_err_reg || seq_err_set ||
                        terminals.external_output_block ||
                        (dual_fault_reg && stop_coast);
   assign decel_cause = dual_fault_reg && !stop_coast && !coast_cause;

   // Output stage responses.
   always_comb begin
      response_next.coast_stop = coast_cause;
      response_next.decel_stop = decel_cause;
      response_next.power_output_enable = !coast_cause;
      response_next.fault_contact = ut_trip_reg || seq_err_reg || dual_fault_reg;
      response_next.undertorque_alarm = ut_trip_reg || ut_trip_set || (ut_warn && blink);
      response_next.sequence_error_lamp = seq_err_reg && blink;
      response_next.output_block_lamp = terminals.external_output_block && blink;
      response_next.dual_direction_fault = dual_fault_reg;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         response_reg <= '0;
      end else begin
         response_reg <= response_next;
      end
   end

   assign response = response_reg;
endmodule

// ---- fdsup_checker_sva.sv ----
// Checker for the drive fault supervisor, watching top-level ports only.
// Assumes it is bound into fdsup_top with the same DUAL_HOLD.
`timescale 1ns/1ns
module fdsup_checker #(
   parameter int DUAL_HOLD = 20
) (
   input wire logic                          clk,
   input wire logic                          sys_rst,
   input wire fdsup_pkg::fdsup_terminal_type terminals,
   input wire fdsup_pkg::fdsup_response_type response
);
   import fdsup_pkg::*;
   logic [7:0] dual_cnt_reg;
   always_ff @(posedge clk) begin
      if (sys_rst || !(terminals.fwd_run && terminals.rev_run)) begin
         dual_cnt_reg <= 8'h00;
      end else if (dual_cnt_reg != 8'hff) begin
         dual_cnt_reg <= dual_cnt_reg + 8'h01;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_block_off; terminals.external_output_block |=> !response.power_output_enable && response.coast_stop; endproperty
   a_block_off: assert property (p_block_off) else $error("output kept under block");
   property p_block_lamp; response.output_block_lamp |-> $past(terminals.external_output_block); endproperty
   a_block_lamp: assert property (p_block_lamp) else $error("block lamp without block");
   property p_seq; terminals.drive_running && $past(terminals.drive_running) && $rose(terminals.sequence_change)
      |-> ##[1:2] response.coast_stop; endproperty
   a_seq: assert property (p_seq) else $error("no coast on sequence change");
   property p_lr; terminals.drive_running && $past(terminals.drive_running) && $changed(terminals.local_remote_sel)
      |-> ##[1:2] response.coast_stop; endproperty
   a_lr: assert property (p_lr) else $error("no coast on source change");
   property p_latch; response.fault_contact |=> response.fault_contact; endproperty
   a_latch: assert property (p_latch) else $error("fault contact released");
   property p_coast; response.coast_stop |-> !response.power_output_enable; endproperty
   a_coast: assert property (p_coast) else $error("power on while coasting");
   property p_dual; (32'(dual_cnt_reg) == DUAL_HOLD + 3) |-> response.dual_direction_fault; endproperty
   a_dual: assert property (p_dual) else $error("direction fault missing");
   property p_dual_stop; response.dual_direction_fault |-> response.decel_stop || response.coast_stop; endproperty
   a_dual_stop: assert property (p_dual_stop) else $error("no stop after direction fault");
   property p_warn; response.undertorque_alarm && !response.fault_contact ##1 !response.undertorque_alarm
      |-> !response.fault_contact; endproperty
   a_warn: assert property (p_warn) else $error("warning moved fault contact");
   c_dual: cover property ($rose(response.dual_direction_fault));
   c_seq: cover property ($rose(response.sequence_error_lamp));
   c_block: cover property ($rose(response.output_block_lamp));
endmodule
bind fdsup_top fdsup_checker #(.DUAL_HOLD(DUAL_HOLD)) fdsup_checker_i (.clk(clk), .sys_rst(sys_rst),
   .terminals(terminals), .response(response));

// ---- fdsup_terminal_model.sv ----
// Model of the control terminals and motor output stage facing the supervisor.
// Assumes the bench drives cmd right after rising edges of clk.
`timescale 1ns/1ns
module fdsup_terminal_model (
   input wire logic                          clk,
   input wire logic                          sys_rst,
   input wire fdsup_pkg::fdsup_terminal_type cmd,
   input wire logic                          allow_misuse,
   input wire fdsup_pkg::fdsup_response_type response,
   output fdsup_pkg::fdsup_terminal_type     terminals,
   output logic                              motor_turning
);
   import fdsup_pkg::*;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         terminals <= '0;
      end else begin
         terminals <= cmd;
         if (!allow_misuse && cmd.fwd_run) begin
            terminals.rev_run <= 1'b0;
         end
         if (!allow_misuse && terminals.drive_running) begin
            terminals.sequence_change  <= terminals.sequence_change;
            terminals.local_remote_sel <= terminals.local_remote_sel;
         end
      end
   end
   always_ff @(posedge clk) begin
      motor_turning <= !sys_rst && terminals.drive_running && response.power_output_enable;
   end
endmodule

// ---- tb.sv ----
// Self-checking bench for the drive fault supervisor.
// Assumes the terminal model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module tb;
   import fdsup_pkg::*;
   localparam int HOLD = 20;
   localparam int PWR = 7, COAST = 6, DECEL = 5, FLT = 4, UT = 3, SEQ = 2, BLK = 1, DUAL = 0;
   localparam logic [1:0] OFF = 2'h0, ON = 2'h1, FL = 2'h2;
   logic               clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, allow_misuse;
   logic [4:0]         avs_address;
   logic [3:0]         avs_byteenable;
   logic [31:0]        avs_writedata, avs_readdata;
   fdsup_terminal_type cmd, terminals;
   fdsup_response_type response;
   logic [31:0]        exp_q[$];
   int                 n_mismatch = 0, num_checks = 0, cycles = 0;
   integer             seed;
   fdsup_top #(.DUAL_HOLD(HOLD), .BLINK_HALF(4)) fdsup_top_i (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .terminals(terminals), .response(response), .irq(irq));
   fdsup_terminal_model fdsup_terminal_model_i (.clk(clk), .sys_rst(sys_rst), .cmd(cmd),
      .allow_misuse(allow_misuse), .response(response), .terminals(terminals), .motor_turning());
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic give_verdict;
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) check(avs_readdata, 32'hdead_beef);
         else check(avs_readdata, exp_q.pop_front());
      end
      if (cycles == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
   endtask
   // Counts highs of one response bit over ten cycles: steady off, steady on or flashing.
   task automatic see(input int b, input logic [1:0] e);
      int n = 0;
      repeat (2) @(posedge clk);
      repeat (10) begin
         @(negedge clk);
         n += int'(response[b] === 1'b1);
      end
      @(posedge clk);
      check(32'(n == 0 ? OFF : n == 10 ? ON : FL), 32'(e));
   endtask
   task automatic rst;
      sys_rst <= 1'b1;
      cmd <= '0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      wr(ADDR_MASK, 32'h0000_001f);
   endtask
   initial begin
      seed = 32'hc80c;
      {sys_rst, avs_read, avs_write, allow_misuse} = 4'h8;
      {avs_address, avs_byteenable, avs_writedata} = '0;
      cmd = '0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) rd(5'(i * 4), i == 4 ? 32'h0000_0020 : 32'h0000_0000);
      bus(1'b1, ADDR_LEVEL, 32'h0000_ffff, 4'h1);
      rd(ADDR_LEVEL, 32'h0000_00ff);
      wr(5'h14, 32'hffff_ffff);
      rd(5'h14, 32'h0000_0000);
      wr(ADDR_LEVEL, 32'h0000_0064);
      wr(ADDR_MASK, 32'h0000_001f);
      cmd.drive_running <= 1'b1;
      cmd.output_current <= 16'($unsigned($random(seed)) % 100);
      cmd.output_torque <= 16'h01f4;
      see(UT, FL);
      see(FLT, OFF);
      see(PWR, ON);
      check(32'(irq), 32'h0000_0001);
      rd(ADDR_STATUS, 32'h0000_0001);
      cmd.output_current <= 16'h0064 + 16'($unsigned($random(seed)) % 1000);
      see(UT, OFF);
      rd(ADDR_STATUS, 32'h0000_0001);
      rd(ADDR_STATUS, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0003);
      cmd.output_current <= 16'h0032;
      cmd.output_torque <= 16'h00c8;
      see(UT, OFF);
      cmd.output_torque <= 16'h0032;
      see(UT, FL);
      cmd.output_current <= 16'h00c8;
      wr(ADDR_CTRL, 32'h0000_0001);
      see(UT, OFF);
      rd(ADDR_STATUS, 32'h0000_0001);
      wr(ADDR_CTRL, 32'h0000_0004);
      cmd.output_current <= 16'h0010;
      see(UT, ON);
      see(PWR, OFF);
      see(COAST, ON);
      cmd.output_current <= 16'h0100;
      see(FLT, ON);
      rd(ADDR_STATUS, 32'h0000_0002);
      rst();
      allow_misuse <= 1'b1;
      cmd.drive_running <= 1'b1;
      see(SEQ, OFF);
      cmd.sequence_change <= 1'b1;
      see(SEQ, FL);
      see(COAST, ON);
      rd(ADDR_STATUS, 32'h0000_0004);
      rst();
      cmd.sequence_change <= 1'b1;
      see(SEQ, OFF);
      cmd.drive_running <= 1'b1;
      see(SEQ, OFF);
      cmd.local_remote_sel <= 1'b1;
      see(SEQ, FL);
      rd(ADDR_STATUS, 32'h0000_0004);
      rst();
      wr(ADDR_MASK, 32'h0000_0000);
      cmd.external_output_block <= 1'b1;
      see(BLK, FL);
      check(32'(irq), 32'h0000_0000);
      wr(ADDR_MASK, 32'h0000_0008);
      see(PWR, OFF);
      check(32'(irq), 32'h0000_0001);
      rd(ADDR_STATUS, 32'h0000_0008);
      cmd.external_output_block <= 1'b0;
      see(PWR, ON);
      check(32'(irq), 32'h0000_0000);
      cmd.fwd_run <= 1'b1;
      cmd.rev_run <= 1'b1;
      repeat (HOLD - 3) @(posedge clk);
      cmd.rev_run <= 1'b0;
      see(DUAL, OFF);
      rd(ADDR_STATUS, 32'h0000_0000);
      cmd.rev_run <= 1'b1;
      repeat (HOLD) @(posedge clk);
      see(DUAL, ON);
      see(DECEL, ON);
      rd(ADDR_STATUS, 32'h0000_0010);
      rst();
      wr(ADDR_CTRL, 32'h0000_0008);
      cmd.fwd_run <= 1'b1;
      cmd.rev_run <= 1'b1;
      repeat (HOLD) @(posedge clk);
      see(COAST, ON);
      see(DECEL, OFF);
      give_verdict();
   end
endmodule
